// >>> hw/chan_test_ctrl.sv
// Functional notes
// - Transmit cutoff floats outputs, drops transmit slot
// - Transmit cutoff overrides both loopback states
// - Receive cutoff zeroes signal before lowpass filter
// - Receive cutoff blocks loopback, tone, feedback
// - Highpass disable bypasses transmit highpass and notch
// - Lower receive gain adds 6.02 dB loss
// - Command CDh returns transmit sample, host mode
// - Armed interrupt on new sample, cleared on host-mode read
// - Interface loopback overwrites transmit with receive
// - Full loopback mutes output, feeds input, stops scaling
// - Scaling code 10000 also enters full loopback
// - Tone bit injects 1 kHz milliwatt into receive
// - Full scale is 4096 units at maximum level
// - Positive input between n,n+1 encodes 128+n
// - Even bits inverted; decoder undoes inversion
`timescale 1ns/100ps
`default_nettype none
`include "chan_test_defs.svh"
module chan_test_ctrl (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [12:0] ANALOG_INPUT,
  input wire logic [12:0] RX_LINEAR,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_PCM,
  input wire logic RX_PCM_VALID,
  output logic [12:0] ANALOG_OUTPUT,
  output logic ANALOG_OUTPUT_ENABLE,
  output logic [12:0] TX_FILTER_INPUT,
  output logic HIGHPASS_BYPASS,
  output logic IMPEDANCE_SCALING_ENABLE,
  output logic BFILTER_ENABLE,
  output logic [7:0] TRANSMIT_PCM_OUTPUT,
  output logic TRANSMIT_PCM_OE_N,
  output logic TIME_SLOT_CONTROL_OUTPUT,
  output logic TIME_SLOT_CONTROL_OE_N,
  output logic TX_SLOT_ACTIVE,
  output logic INTERRUPT
);
  logic rst_meta_ff, rst_sync_ff;
  wire logic rst_n = rst_sync_ff;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Encoder: magnitude in 4096-unit scale, sign separate
  function automatic chan_test_pkg::law_char_t alaw_encode(input logic [12:0] s);
    logic [11:0] mag;
    logic [2:0] seg;
    logic [3:0] step;
    logic [7:0] pre;
    mag = s[12] ? 12'((~s) + 13'h0001) : s[11:0];
    if (s[12] && mag == 12'h000) begin
      mag = 12'hfff;
    end
    seg = 3'h0;
    step = mag[4:1];
    for (int i = 7; i >= 1; i--) begin
      if (seg == 3'h0 && mag[i + 4]) begin
        seg = 3'(i);
        step = 4'(mag >> i);
      end
    end
    pre = {~s[12], seg, step};
    alaw_encode = pre ^ `EVEN_MASK;
  endfunction

  // Decoder: undo inversion, expand to mid value of the interval
  function automatic logic [12:0] alaw_decode(input chan_test_pkg::law_char_t c);
    logic [7:0] pre;
    logic [11:0] mag;
    pre = c ^ `EVEN_MASK;
    if (pre[6:4] == 3'h0) begin
      mag = {7'h00, pre[3:0], 1'b1};
    end else begin
      mag = 12'(({7'h01, pre[3:0], 1'b1}) << (pre[6:4] - 3'h1));
    end
    alaw_decode = pre[7] ? {1'b0, mag} : 13'((~{1'b0, mag}) + 13'h0001);
  endfunction

  logic [9:0] control_ff;
  logic [4:0] scaling_ff;
  logic [1:0] status_ff, mask_ff;
  logic [7:0] tx_char_ff, command_ff, rx_char_ff;
  logic [12:0] rx_sample_ff;
  logic [13:0] div_ff;
  logic [2:0] tone_ff;
  logic sample_tick;
  chan_test_pkg::bus_state_t bus_ff;
  logic [31:0] rdata_ff;
  logic [1:0] bresp_ff, rresp_ff;

  wire logic tx_cut = control_ff[`B_TX_CUTOFF];
  wire logic rx_cut = control_ff[`B_RX_CUTOFF];
  wire logic full_loop = control_ff[`B_FULL_LOOP] || scaling_ff == `SCALING_LOOP_CODE;
  wire logic host_mode = control_ff[`B_HOST_MODE];

  // Bus: address and data taken together, one access at a time
  wire logic wr_go = bus_ff == chan_test_pkg::ST_IDLE && S_AXI_AWVALID && S_AXI_WVALID;
  wire logic rd_go = bus_ff == chan_test_pkg::ST_IDLE && S_AXI_ARVALID && !wr_go;
  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY = wr_go;
  assign S_AXI_ARREADY = rd_go;
  assign S_AXI_BVALID = bus_ff == chan_test_pkg::ST_WRESP;
  assign S_AXI_RVALID = bus_ff == chan_test_pkg::ST_RRESP;
  assign S_AXI_BRESP = bresp_ff;
  assign S_AXI_RRESP = rresp_ff;
  assign S_AXI_RDATA = rdata_ff;

  function automatic logic known(input logic [11:0] a);
    known = a == `OFF_CONTROL || a == `OFF_SCALING || a == `OFF_TXSAMPLE || a == `OFF_STATUS ||
            a == `OFF_MASK || a == `OFF_RXSAMPLE || a == `OFF_COMMAND || a == `OFF_CHARS;
  endfunction

  wire logic [11:0] waddr = {S_AXI_AWADDR[11:2], 2'b00};
  wire logic [11:0] raddr = {S_AXI_ARADDR[11:2], 2'b00};
  wire logic wr_ctl = wr_go && waddr == `OFF_CONTROL && S_AXI_WSTRB[0];
  wire logic wr_ctl_hi = wr_go && waddr == `OFF_CONTROL && S_AXI_WSTRB[1];
  wire logic wr_cmd = wr_go && waddr == `OFF_COMMAND && S_AXI_WSTRB[0];
  wire logic rd_tx = rd_go && raddr == `OFF_TXSAMPLE;
  // A command CDh read counts only in host port mode
  wire logic cmd_read = wr_cmd && host_mode && S_AXI_WDATA[7:0] == `CMD_READ_TX;

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      bus_ff <= chan_test_pkg::ST_IDLE;
      bresp_ff <= 2'h0;
      rresp_ff <= 2'h0;
    end else begin
      case (bus_ff)
        chan_test_pkg::ST_IDLE: begin
          if (wr_go) begin
            bus_ff <= chan_test_pkg::ST_WRESP;
            bresp_ff <= known(waddr) ? 2'h0 : 2'h2;
          end else if (rd_go) begin
            bus_ff <= chan_test_pkg::ST_RRESP;
            rresp_ff <= known(raddr) ? 2'h0 : 2'h2;
          end
        end
        chan_test_pkg::ST_WRESP: begin
          if (S_AXI_BREADY) begin
            bus_ff <= chan_test_pkg::ST_IDLE;
          end
        end
        chan_test_pkg::ST_RRESP: begin
          if (S_AXI_RREADY) begin
            bus_ff <= chan_test_pkg::ST_IDLE;
          end
        end
        default: bus_ff <= chan_test_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_go) begin
      case (raddr)
        `OFF_CONTROL: rdata_ff <= {22'h000000, control_ff};
        `OFF_SCALING: rdata_ff <= {27'h0000000, scaling_ff};
        `OFF_TXSAMPLE: rdata_ff <= host_mode ? {24'h000000, tx_char_ff} : 32'h0000_0000;
        `OFF_STATUS: rdata_ff <= {30'h00000000, status_ff};
        `OFF_MASK: rdata_ff <= {30'h00000000, mask_ff};
        `OFF_RXSAMPLE: rdata_ff <= {19'h00000, rx_sample_ff};
        `OFF_COMMAND: rdata_ff <= {24'h000000, command_ff};
        `OFF_CHARS: rdata_ff <= {24'h000000, rx_char_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      control_ff <= `CONTROL_RESET;
      scaling_ff <= `SCALING_RESET;
      mask_ff <= 2'h0;
      command_ff <= 8'h00;
    end else if (wr_go) begin
      if (wr_ctl) begin
        control_ff[7:0] <= S_AXI_WDATA[7:0];
      end
      if (wr_ctl_hi) begin
        control_ff[9:8] <= S_AXI_WDATA[9:8];
      end
      if (waddr == `OFF_SCALING && S_AXI_WSTRB[0]) begin
        scaling_ff <= S_AXI_WDATA[4:0];
      end
      if (waddr == `OFF_MASK && S_AXI_WSTRB[0]) begin
        mask_ff <= S_AXI_WDATA[1:0];
      end
      if (wr_cmd) begin
        command_ff <= S_AXI_WDATA[7:0];
      end
    end
  end

  // Sample clock and 1 kHz tone at 8 steps per cycle
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 14'h0000;
      tone_ff <= 3'h0;
    end else if (div_ff == 14'(`SAMPLE_CYCLES - 1)) begin
      div_ff <= 14'h0000;
      tone_ff <= tone_ff + 3'h1;
    end else begin
      div_ff <= div_ff + 14'h0001;
    end
  end
  assign sample_tick = div_ff == 14'(`SAMPLE_CYCLES - 1);

  // Digital milliwatt: eight-step A-law sequence repeated each millisecond
  function automatic chan_test_pkg::law_char_t tone_char(input logic [2:0] ph);
    case (ph)
      3'h0: tone_char = 8'h34;
      3'h1: tone_char = 8'h21;
      3'h2: tone_char = 8'h21;
      3'h3: tone_char = 8'h34;
      3'h4: tone_char = 8'hb4;
      3'h5: tone_char = 8'ha1;
      3'h6: tone_char = 8'ha1;
      3'h7: tone_char = 8'hb4;
      default: tone_char = 8'h34;
    endcase
  endfunction

  // Receive path: tone replaces input; cutoff wins over tone and loss
  logic [12:0] rx_in, rx_path;
  always_comb begin
    rx_in = RX_PCM_VALID ? alaw_decode(RX_PCM) : RX_LINEAR;
    if (control_ff[`B_RX_TONE]) begin
      rx_in = alaw_decode(tone_char(tone_ff));
    end
    rx_path = control_ff[`B_LOWER_GAIN] ? {rx_in[12], rx_in[12:1]} : rx_in;
    if (rx_cut) begin
      rx_path = 13'h0000;
    end
  end

  logic rx_event;
  assign rx_event = sample_tick || RX_VALID;
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      rx_sample_ff <= 13'h0000;
      rx_char_ff <= 8'h00;
    end else if (rx_event) begin
      rx_sample_ff <= rx_path;
      rx_char_ff <= alaw_encode(rx_path);
    end
  end

  // Transmit path entry: full loopback replaces the analog input
  logic [12:0] tx_src;
  always_comb begin
    tx_src = ANALOG_INPUT;
    if (full_loop && !rx_cut) begin
      tx_src = rx_sample_ff;
    end else if (full_loop) begin
      tx_src = 13'h0000;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      TX_FILTER_INPUT <= 13'h0000;
      ANALOG_OUTPUT <= 13'h0000;
      tx_char_ff <= 8'h00;
    end else if (sample_tick) begin
      TX_FILTER_INPUT <= tx_src;
      ANALOG_OUTPUT <= full_loop ? 13'h0000 : rx_sample_ff;
      if (control_ff[`B_IF_LOOP]) begin
        tx_char_ff <= rx_char_ff;
      end else begin
        tx_char_ff <= alaw_encode(tx_src);
      end
    end
  end

  assign ANALOG_OUTPUT_ENABLE = !full_loop;
  assign IMPEDANCE_SCALING_ENABLE = !full_loop;
  assign BFILTER_ENABLE = !rx_cut;
  assign HIGHPASS_BYPASS = control_ff[`B_HP_DISABLE];

  // Cutoff is checked last so it beats either loopback
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      TRANSMIT_PCM_OUTPUT <= 8'h00;
    end else begin
      TRANSMIT_PCM_OUTPUT <= tx_cut ? 8'h00 : tx_char_ff;
    end
  end
  assign TRANSMIT_PCM_OE_N = tx_cut;
  assign TIME_SLOT_CONTROL_OE_N = tx_cut;
  assign TIME_SLOT_CONTROL_OUTPUT = 1'b1;
  assign TX_SLOT_ACTIVE = !tx_cut;

  // New sample sets over a same-cycle clear; a host-mode read clears it
  wire logic tx_new = sample_tick && control_ff[`B_ARM_TX_INT];
  wire logic tx_read = (rd_tx && host_mode) || cmd_read;
  wire logic st_clear = wr_go && waddr == `OFF_STATUS && S_AXI_WSTRB[0];
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= 2'h0;
    end else begin
      if (tx_new) begin
        status_ff[`S_TX_NEW] <= 1'b1;
      end else if (tx_read || (st_clear && S_AXI_WDATA[`S_TX_NEW])) begin
        status_ff[`S_TX_NEW] <= 1'b0;
      end
      if (rx_event) begin
        status_ff[`S_RX_NEW] <= 1'b1;
      end else if (st_clear && S_AXI_WDATA[`S_RX_NEW]) begin
        status_ff[`S_RX_NEW] <= 1'b0;
      end
    end
  end
  assign INTERRUPT = |(status_ff & mask_ff);
endmodule
`default_nettype wire

// >>> hw/chan_test_defs.svh
`ifndef CHAN_TEST_DEFS_SVH
`define CHAN_TEST_DEFS_SVH
// Register byte offsets
`define OFF_CONTROL 12'h000
`define OFF_SCALING 12'h004
`define OFF_TXSAMPLE 12'h008
`define OFF_STATUS 12'h00c
`define OFF_MASK 12'h010
`define OFF_RXSAMPLE 12'h014
`define OFF_COMMAND 12'h018
`define OFF_CHARS 12'h01c
// Control field positions
`define B_TX_CUTOFF 0
`define B_RX_CUTOFF 1
`define B_HP_DISABLE 2
`define B_LOWER_GAIN 3
`define B_ARM_TX_INT 4
`define B_IF_LOOP 5
`define B_FULL_LOOP 6
`define B_RX_TONE 7
`define B_SLOT_LOOP 8
`define B_HOST_MODE 9
`define CONTROL_RESET 10'h000
`define SCALING_RESET 5'h00
`define SCALING_LOOP_CODE 5'h10
`define CMD_READ_TX 8'hcd
// Status bits
`define S_TX_NEW 0
`define S_RX_NEW 1
// Companding: 4096 units full scale at maximum level
`define FULL_SCALE 13'h1000
`define EVEN_MASK 8'h55
// Sample rate 8 kHz, tone 1 kHz
`define CLOCK_HZ 100000000
`define SAMPLE_HZ 8000
`define SAMPLE_CYCLES (`CLOCK_HZ / `SAMPLE_HZ)
`define TONE_STEPS 8
`endif

// >>> hw/chan_test_pkg.sv
package chan_test_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRESP = 3'b010,
    ST_RRESP = 3'b100
  } bus_state_t;
  typedef logic [7:0] law_char_t;
endpackage

// >>> bench/chan_test_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "chan_test_defs.svh"
module chan_test_props (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic ANALOG_OUTPUT_ENABLE,
  input wire logic HIGHPASS_BYPASS,
  input wire logic IMPEDANCE_SCALING_ENABLE,
  input wire logic BFILTER_ENABLE,
  input wire logic TRANSMIT_PCM_OE_N,
  input wire logic TIME_SLOT_CONTROL_OE_N,
  input wire logic TX_SLOT_ACTIVE,
  input wire logic INTERRUPT
);
  logic [9:0] ctl_ff;
  logic [4:0] scl_ff;
  logic [1:0] msk_ff;
  wire wr_go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  wire full_digital_loopback = (ctl_ff[6] || scl_ff == `SCALING_LOOP_CODE) && !ctl_ff[1];
  // A transmit-sample read clears the flag only in host port mode
  wire rd_tx = S_AXI_ARVALID && S_AXI_ARREADY && ctl_ff[9] && S_AXI_ARADDR == `OFF_TXSAMPLE;
  wire cmd = wr_go && ctl_ff[9] && S_AXI_AWADDR == `OFF_COMMAND && S_AXI_WDATA[7:0] == `CMD_READ_TX;
  // Mirror of the software-visible settings, rebuilt from taken writes
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ctl_ff <= 10'h000;
      scl_ff <= 5'h00;
      msk_ff <= 2'h0;
    end else if (wr_go) begin
      if (S_AXI_AWADDR == `OFF_CONTROL) ctl_ff <= S_AXI_WDATA[9:0];
      if (S_AXI_AWADDR == `OFF_SCALING) scl_ff <= S_AXI_WDATA[4:0];
      if (S_AXI_AWADDR == `OFF_MASK) msk_ff <= S_AXI_WDATA[1:0];
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  property p_txoff; ctl_ff[0] && $past(ctl_ff[0], 2) |-> TRANSMIT_PCM_OE_N && TIME_SLOT_CONTROL_OE_N && !TX_SLOT_ACTIVE; endproperty
  a_txoff: assert property (p_txoff) else $error("transmit side not floated");
  property p_txon; !ctl_ff[0] && !$past(ctl_ff[0], 2) |-> !TRANSMIT_PCM_OE_N; endproperty
  a_txon: assert property (p_txon) else $error("transmit output floated");
  property p_hp; HIGHPASS_BYPASS == ctl_ff[2]; endproperty
  a_hp: assert property (p_hp) else $error("highpass bypass mismatch");
  property p_bfil; ctl_ff[1] && $past(ctl_ff[1], 2) |-> !BFILTER_ENABLE; endproperty
  a_bfil: assert property (p_bfil) else $error("feedback path open");
  property p_fdl; full_digital_loopback && $past(full_digital_loopback, 2) |-> !ANALOG_OUTPUT_ENABLE && !IMPEDANCE_SCALING_ENABLE; endproperty
  a_fdl: assert property (p_fdl) else $error("loopback output still on");
  property p_irq0; msk_ff == 2'h0 && $past(msk_ff == 2'h0) |-> !INTERRUPT; endproperty
  a_irq0: assert property (p_irq0) else $error("masked interrupt seen");
  property p_clr; (rd_tx || cmd) && msk_ff == 2'h1 |-> ##2 !INTERRUPT; endproperty
  a_clr: assert property (p_clr) else $error("interrupt not cleared");
  property p_bv; wr_go |=> S_AXI_BVALID; endproperty
  a_bv: assert property (p_bv) else $error("write response late");
  property p_rv; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_rv: assert property (p_rv) else $error("read response late");
endmodule
bind chan_test_ctrl chan_test_props u_props (.CLOCK, .RESETN, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_WDATA, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RVALID, .ANALOG_OUTPUT_ENABLE, .HIGHPASS_BYPASS, .IMPEDANCE_SCALING_ENABLE, .BFILTER_ENABLE,
  .TRANSMIT_PCM_OE_N, .TIME_SLOT_CONTROL_OE_N, .TX_SLOT_ACTIVE, .INTERRUPT);
`default_nettype wire

// >>> bench/chan_test_far.sv
`timescale 1ns/100ps
`default_nettype none
module chan_test_far #(
  parameter logic [12:0] TX_LEVEL = 13'h1f00,
  parameter logic [12:0] RX_LEVEL = 13'h0200
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic [12:0] analog_input,
  output logic [12:0] rx_linear,
  output logic rx_valid,
  output logic [7:0] rx_pcm,
  output logic rx_pcm_valid
);
  logic [5:0] cnt_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_ff <= 6'h00;
    else cnt_ff <= cnt_ff + 6'h01;
  end
  assign rx_valid = cnt_ff == 6'h3f;
  // Outside the strobe the lane shows the inverse, so a stale capture is caught
  assign rx_linear = rx_valid ? RX_LEVEL : ~RX_LEVEL;
  assign analog_input = TX_LEVEL;
  assign rx_pcm = 8'hd5;
  assign rx_pcm_valid = 1'b0;
endmodule
`default_nettype wire

// >>> bench/channel_test_states_alaw_codec_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "chan_test_defs.svh"
module channel_test_states_alaw_codec_tb_top;
  logic clock, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [1:0] rresp, rrv;
  logic awready, bvalid, arready, rvalid, irq, pcm_oe_n, tsc_oe_n, slot_act, aoe, ise, hpb, bfe, rx_v, rx_pv;
  logic [7:0] tx_pcm, rx_pcm;
  logic [12:0] ain, rx_lin;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  chan_test_ctrl uut (
    .CLOCK(clock), .RESETN(resetn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(), .S_AXI_BRESP(),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .ANALOG_INPUT(ain), .RX_LINEAR(rx_lin), .RX_VALID(rx_v), .RX_PCM(rx_pcm),
    .RX_PCM_VALID(rx_pv), .ANALOG_OUTPUT(), .ANALOG_OUTPUT_ENABLE(aoe), .TX_FILTER_INPUT(),
    .HIGHPASS_BYPASS(hpb), .IMPEDANCE_SCALING_ENABLE(ise), .BFILTER_ENABLE(bfe), .TRANSMIT_PCM_OUTPUT(tx_pcm),
    .TRANSMIT_PCM_OE_N(pcm_oe_n), .TIME_SLOT_CONTROL_OUTPUT(), .TIME_SLOT_CONTROL_OE_N(tsc_oe_n),
    .TX_SLOT_ACTIVE(slot_act), .INTERRUPT(irq)
  );
  chan_test_far far (.clk(clock), .rst_n(resetn), .analog_input(ain), .rx_linear(rx_lin), .rx_valid(rx_v),
    .rx_pcm(rx_pcm), .rx_pcm_valid(rx_pv));
  task end_sim;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Ready is looked at on the falling edge, so the release lands right after the taking edge
  task hs(input int k);
    int n;
    logic h;
    n = 0;
    h = 1'b0;
    while (h !== 1'b1 && n < 100) begin
      @(negedge clock);
      h = (k == 0) ? awready : (k == 1) ? bvalid : (k == 2) ? arready : rvalid;
      rdv = rdata;
      rrv = rresp;
      @(posedge clock);
      n++;
    end
    if (h !== 1'b1) chk("handshake", 1, 0);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hs(0);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    hs(1);
    bready <= 1'b0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hs(2);
    arvalid <= 1'b0;
    hs(3);
    rready <= 1'b0;
  endtask
  task settle;
    repeat (2) @(negedge clock);
  endtask
  task wirq;
    int n;
    n = 0;
    @(negedge clock);
    while (irq !== 1'b1 && n < 14000) begin
      @(negedge clock);
      n++;
    end
    chk("irq", 1, irq);
  endtask
  // Two sample ticks per case, so any pipeline lag has flushed before the read
  task samp(input logic [31:0] c, input logic [7:0] e);
    wr(`OFF_CONTROL, c);
    wirq();
    wr(`OFF_MASK, 32'h0);
    settle();
    chk("masked", 0, irq);
    wr(`OFF_MASK, 32'h1);
    settle();
    chk("unmasked", 1, irq);
    wr(`OFF_COMMAND, {24'h0, `CMD_READ_TX});
    wirq();
    rd(`OFF_TXSAMPLE);
    chk("tx_char", {24'h0, e}, rdv);
    settle();
    chk("pcm_out", {24'h0, e}, {24'h0, tx_pcm});
    chk("irq_clear", 0, irq);
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 95000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    resetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    rd(`OFF_CONTROL);
    chk("ctl_reset", 0, rdv);
    rd(12'h020);
    chk("unmapped", 2, rrv);
    wr(`OFF_CONTROL, 32'h141);
    settle();
    chk("cutoff", 5'b11000, {pcm_oe_n, tsc_oe_n, slot_act, aoe, ise});
    rd(`OFF_CONTROL);
    chk("ctl", 32'h141, rdv);
    wr(`OFF_CONTROL, 32'h006);
    settle();
    chk("hp_rx", 2'b10, {hpb, bfe});
    wr(`OFF_CONTROL, 32'h0);
    wr(`OFF_SCALING, 32'h10);
    settle();
    chk("scl_loop", 2'b00, {aoe, ise});
    wr(`OFF_SCALING, 32'h0f);
    settle();
    chk("scl_off", 2'b11, {aoe, ise});
    wr(`OFF_MASK, 32'h1);
    samp(32'h238, 8'h95);
    samp(32'h210, 8'h15);
    samp(32'h232, 8'hd5);
    wr(`OFF_CONTROL, 32'h010);
    rd(`OFF_TXSAMPLE);
    chk("no_host", 0, rdv);
    end_sim();
  end
endmodule
`default_nettype wire
